//--- ttm_pkg.sv
package ttm_pkg;

    // ------------------------------------------------------------
    // widths and channel layout
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned DATA_W   = 8;
    localparam int unsigned NTHR     = 6;
    localparam int unsigned NCH      = 2 * NTHR + 2;
    localparam int unsigned CH_RISE  = 0;           // first rise comparator
    localparam int unsigned CH_REL   = NTHR;        // first release comparator
    localparam int unsigned CH_SDT   = 2 * NTHR;    // shutdown trip
    localparam int unsigned CH_SDR   = 2 * NTHR + 1; // shutdown release

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FLAG   = 8'h00;
    localparam logic [7:0] OFS_MASK   = 8'h01;
    localparam logic [7:0] OFS_SENSE  = 8'h02;
    localparam logic [7:0] OFS_CTRL   = 8'h03;
    localparam logic [7:0] OFS_STATUS = 8'h04;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned SD_BIT     = 6;  // shutdown bit in flag/mask/sense
    localparam int unsigned CTRL_EN    = 0;
    localparam int unsigned CTRL_AON   = 1;
    localparam int unsigned STAT_ON    = 0;
    localparam int unsigned STAT_SMPL  = 1;
    localparam logic [6:0] FLAG_RST    = 7'h00;
    localparam logic [6:0] MASK_RST    = 7'h7F;
    localparam logic       EN_RST      = 1'b1;
    localparam logic       AON_RST     = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ        = 125;
    localparam int unsigned DB_TIME_US     = 10;
    localparam int unsigned SMPL_WIN_US    = 450;
    localparam int unsigned SMPL_INT_US    = 3000; // 3.0 ms
    localparam int unsigned DB_CYC         = DB_TIME_US * CLK_MHZ;
    localparam int unsigned WIN_CYC_DEF    = SMPL_WIN_US * CLK_MHZ;
    localparam int unsigned INT_CYC_DEF    = SMPL_INT_US * CLK_MHZ;
    localparam int unsigned DB_CNT_W       = $clog2(DB_CYC + 1);
    localparam int unsigned PER_W          = $clog2(INT_CYC_DEF + 1);

    // ------------------------------------------------------------
    // monitor power modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MON_OFF,
        MON_AON,
        MON_SMPL
    } ttm_mode_t;

endpackage

//--- ttm_db_if.sv
`timescale 1ns/1ps
interface ttm_db_if;
    logic [ttm_pkg::NCH-1:0] raw;
    logic [ttm_pkg::NCH-1:0] clean;
    logic                    run;

    modport src (output raw, output run, input clean);
    modport deb (input raw, input run, output clean);
endinterface

//--- ttm_debounce.sv
`timescale 1ns/1ps
module ttm_debounce (
    input  wire logic sys_clk,
    input  wire logic rst,
    ttm_db_if.deb     db
);

    // ------------------------------------------------------------
    // per channel debounce counters
    // ------------------------------------------------------------
    logic [ttm_pkg::DB_CNT_W-1:0] cnt_r   [ttm_pkg::NCH];
    logic [ttm_pkg::DB_CNT_W-1:0] cnt_nxt [ttm_pkg::NCH];
    logic [ttm_pkg::NCH-1:0]      clean_r;
    logic [ttm_pkg::NCH-1:0]      clean_nxt;

    localparam logic [ttm_pkg::DB_CNT_W-1:0] DB_LAST =
        ttm_pkg::DB_CNT_W'(ttm_pkg::DB_CYC - 1);

    // both edges must persist the full time before clean follows
    always_comb begin
        clean_nxt = clean_r;
        for (int i = 0; i < ttm_pkg::NCH; i++) begin
            cnt_nxt[i] = cnt_r[i];
            if (!db.run) begin
                cnt_nxt[i] = '0;   // unpowered comparators are not trusted
            end else if (db.raw[i] == clean_r[i]) begin
                cnt_nxt[i] = '0;
            end else if (cnt_r[i] == DB_LAST) begin
                cnt_nxt[i]   = '0;
                clean_nxt[i] = db.raw[i];
            end else begin
                cnt_nxt[i] = cnt_r[i] + 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clean_r <= '0;
            for (int i = 0; i < ttm_pkg::NCH; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            clean_r <= clean_nxt;
            for (int i = 0; i < ttm_pkg::NCH; i++) begin
                cnt_r[i] <= cnt_nxt[i];
            end
        end
    end

    assign db.clean = clean_r;

endmodule

//--- ttm_monitor.sv
`timescale 1ns/1ps
// Summary of operation
// - rising past a threshold sets its flag
// - six thresholds: flag, sense and mask each
// - sense releases below threshold hysteresis or when enable is low
// - shutdown trips, held until hysteresis release
// - enable bit low keeps monitor powered off
// - run with always-on keeps monitor powered
// - otherwise 450 us window every 3.0 ms
// - standby forces sampling whenever enabled
// - comparators debounced 10 us both directions
// - only centre die sensor feeds this logic
module ttm_monitor #(
    parameter int unsigned WIN_CYC = ttm_pkg::WIN_CYC_DEF,
    parameter int unsigned INT_CYC = ttm_pkg::INT_CYC_DEF
) (
    input  wire logic                        sys_clk,
    input  wire logic                        rst,
    input  wire logic                        run_state,
    input  wire logic [ttm_pkg::NTHR-1:0]    cmp_rise,
    input  wire logic [ttm_pkg::NTHR-1:0]    cmp_release,
    input  wire logic                        cmp_sd_trip,
    input  wire logic                        cmp_sd_release,
    input  wire logic [ttm_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [ttm_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [ttm_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             monitor_power,
    output logic                             thermal_shutdown,
    output logic                             thermal_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // hardware set beats a software clear in the same cycle
    function automatic logic [6:0] sticky_next(
        input logic [6:0] cur,
        input logic [6:0] set,
        input logic [6:0] clr
    );
        sticky_next = (cur & ~clr) | set;
    endfunction

    // write strobe decode for one register
    function automatic logic wr_hit(
        input logic                       wr,
        input logic [ttm_pkg::ADDR_W-1:0] addr,
        input logic [ttm_pkg::ADDR_W-1:0] ofs
    );
        wr_hit = wr && (addr == ofs);
    endfunction

    localparam logic [ttm_pkg::PER_W-1:0] WIN_LEN =
        ttm_pkg::PER_W'(WIN_CYC);
    localparam logic [ttm_pkg::PER_W-1:0] PER_LAST =
        ttm_pkg::PER_W'(INT_CYC - 1);

    // ------------------------------------------------------------
    // comparator synchronisers
    // ------------------------------------------------------------
    logic [ttm_pkg::NCH-1:0] cmp_raw;
    logic [ttm_pkg::NCH-1:0] cmp_meta_r;
    logic [ttm_pkg::NCH-1:0] cmp_sync_r;

    // all inputs come from the centre die sensor only
    assign cmp_raw = {cmp_sd_release, cmp_sd_trip,
                      cmp_release, cmp_rise};

    // analog comparators toggle asynchronously to sys_clk
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cmp_meta_r <= '0;
            cmp_sync_r <= '0;
        end else begin
            cmp_meta_r <= cmp_raw;
            cmp_sync_r <= cmp_meta_r;
        end
    end

    // ------------------------------------------------------------
    // control register state
    // ------------------------------------------------------------
    logic       mon_en_r;
    logic       mon_en_nxt;
    logic       mon_aon_r;
    logic       mon_aon_nxt;
    logic [6:0] mask_r;
    logic [6:0] mask_nxt;

    // plain read-write control bits
    always_comb begin
        mon_en_nxt  = mon_en_r;
        mon_aon_nxt = mon_aon_r;
        mask_nxt    = mask_r;
        if (wr_hit(reg_wr, reg_addr, ttm_pkg::OFS_CTRL)) begin
            mon_en_nxt  = reg_wdata[ttm_pkg::CTRL_EN];
            mon_aon_nxt = reg_wdata[ttm_pkg::CTRL_AON];
        end
        if (wr_hit(reg_wr, reg_addr, ttm_pkg::OFS_MASK)) begin
            mask_nxt = reg_wdata[6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mon_en_r  <= ttm_pkg::EN_RST;
            mon_aon_r <= ttm_pkg::AON_RST;
            mask_r    <= ttm_pkg::MASK_RST;
        end else begin
            mon_en_r  <= mon_en_nxt;
            mon_aon_r <= mon_aon_nxt;
            mask_r    <= mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // monitor power sequencing
    // ------------------------------------------------------------
    ttm_pkg::ttm_mode_t          mode_r;
    ttm_pkg::ttm_mode_t          mode_nxt;
    logic [ttm_pkg::PER_W-1:0]   per_r;
    logic [ttm_pkg::PER_W-1:0]   per_nxt;
    logic                        power_nxt;
    logic                        power_r;

    // mode choice, then the burst timer for sampling mode
    always_comb begin
        if (!mon_en_r) begin
            mode_nxt = ttm_pkg::MON_OFF;
        end else if (run_state && mon_aon_r) begin
            mode_nxt = ttm_pkg::MON_AON;
        end else begin
            mode_nxt = ttm_pkg::MON_SMPL;
        end
        per_nxt = '0;
        if (mode_nxt == ttm_pkg::MON_SMPL &&
            mode_r == ttm_pkg::MON_SMPL) begin
            // new bursts begin with a fresh window on mode entry
            per_nxt = (per_r == PER_LAST) ? '0 : per_r + 1'b1;
        end
        unique case (mode_nxt)
            ttm_pkg::MON_OFF:  power_nxt = 1'b0;
            ttm_pkg::MON_AON:  power_nxt = 1'b1;
            ttm_pkg::MON_SMPL: power_nxt = (per_nxt < WIN_LEN);
            default:           power_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_r  <= ttm_pkg::MON_OFF;
            per_r   <= '0;
            power_r <= 1'b0;
        end else begin
            mode_r  <= mode_nxt;
            per_r   <= per_nxt;
            power_r <= power_nxt;
        end
    end

    assign monitor_power = power_r;

    // ------------------------------------------------------------
    // debouncing
    // ------------------------------------------------------------
    ttm_db_if db_bus ();

    assign db_bus.raw = cmp_sync_r;
    // comparators only count while the monitor is powered
    assign db_bus.run = power_r;

    ttm_debounce u_debounce (
        .sys_clk (sys_clk),
        .rst     (rst),
        .db      (db_bus.deb)
    );

    // ------------------------------------------------------------
    // sense with hysteresis, shutdown latch
    // ------------------------------------------------------------
    logic [ttm_pkg::NTHR-1:0] rise_c;
    logic [ttm_pkg::NTHR-1:0] rel_c;
    logic [ttm_pkg::NTHR-1:0] sense_r;
    logic [ttm_pkg::NTHR-1:0] sense_nxt;
    logic                     sd_r;
    logic                     sd_nxt;

    assign rise_c = db_bus.clean[ttm_pkg::CH_RISE +: ttm_pkg::NTHR];
    assign rel_c  = db_bus.clean[ttm_pkg::CH_REL +: ttm_pkg::NTHR];

    // the release comparator sits 5 C below each threshold
    always_comb begin
        sense_nxt = sense_r;
        for (int i = 0; i < ttm_pkg::NTHR; i++) begin
            if (!mon_en_r) begin
                sense_nxt[i] = 1'b0;
            end else if (rise_c[i]) begin
                sense_nxt[i] = 1'b1;
            end else if (!rel_c[i]) begin
                sense_nxt[i] = 1'b0;
            end
        end
        // restart stays blocked until cooled 15 C below trip
        sd_nxt = sd_r;
        if (db_bus.clean[ttm_pkg::CH_SDT]) begin
            sd_nxt = 1'b1;
        end else if (!db_bus.clean[ttm_pkg::CH_SDR]) begin
            sd_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sense_r <= '0;
            sd_r    <= 1'b0;
        end else begin
            sense_r <= sense_nxt;
            sd_r    <= sd_nxt;
        end
    end

    assign thermal_shutdown = sd_r;

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    logic [6:0] flag_r;
    logic [6:0] flag_nxt;
    logic [6:0] flag_set;
    logic [6:0] flag_clr;
    logic       irq_r;
    logic       irq_nxt;

    // a flag sets on each new assertion of its sense bit
    always_comb begin
        flag_set = {sd_nxt & ~sd_r, sense_nxt & ~sense_r};
        flag_clr = '0;
        if (wr_hit(reg_wr, reg_addr, ttm_pkg::OFS_FLAG)) begin
            flag_clr = reg_wdata[6:0];
        end
        flag_nxt = sticky_next(flag_r, flag_set, flag_clr);
        irq_nxt  = |(flag_nxt & ~mask_nxt);
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flag_r <= ttm_pkg::FLAG_RST;
            irq_r  <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign thermal_irq = irq_r;

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [ttm_pkg::DATA_W-1:0] rdata_r;
    logic [ttm_pkg::DATA_W-1:0] rdata_nxt;

    // data stand only in the cycle after the strobe
    always_comb begin
        rdata_nxt = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ttm_pkg::OFS_FLAG:   rdata_nxt = {1'b0, flag_r};
                ttm_pkg::OFS_MASK:   rdata_nxt = {1'b0, mask_r};
                ttm_pkg::OFS_SENSE:  rdata_nxt = {1'b0, sd_r, sense_r};
                ttm_pkg::OFS_CTRL: begin
                    rdata_nxt[ttm_pkg::CTRL_EN]  = mon_en_r;
                    rdata_nxt[ttm_pkg::CTRL_AON] = mon_aon_r;
                end
                ttm_pkg::OFS_STATUS: begin
                    rdata_nxt[ttm_pkg::STAT_ON]   = power_r;
                    rdata_nxt[ttm_pkg::STAT_SMPL] =
                        (mode_r == ttm_pkg::MON_SMPL);
                end
                default:             rdata_nxt = '0;  // unmapped reads 0
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

endmodule

//--- ttm_monitor_assertions.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checker
// ------------------------------------------------------------
module ttm_monitor_chk #(
    parameter int unsigned WIN_CYC = 20,
    parameter int unsigned INT_CYC = 100
) (
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       run_state,
    input wire logic                       cmp_sd_trip,
    input wire logic                       cmp_sd_release,
    input wire logic [ttm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [ttm_pkg::DATA_W-1:0] reg_wdata,
    input wire logic                       reg_wr,
    input wire logic                       reg_rd,
    input wire logic [ttm_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                       monitor_power,
    input wire logic                       thermal_shutdown,
    input wire logic                       thermal_irq
);
    logic [1:0]  ctl_r;
    logic [11:0] hi_r;
    logic [11:0] lo_r;
    logic [31:0] on_r;
    logic [31:0] off_r;
    wire         smpl = ctl_r[0] && (!ctl_r[1] || !run_state);

    // shadow of the control bits plus run-length counters; hi_r and lo_r saturate
    // so long quiet spells never wrap back below the debounce figure
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctl_r <= 2'h3;
            hi_r  <= 12'h000;
            lo_r  <= 12'h000;
            on_r  <= 32'h0;
            off_r <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == ttm_pkg::OFS_CTRL)
                ctl_r <= reg_wdata[1:0];
            hi_r  <= !cmp_sd_trip ? 12'h000
                                  : (&hi_r ? hi_r : hi_r + 12'h001);
            lo_r  <= cmp_sd_release ? 12'h000
                                    : (&lo_r ? lo_r : lo_r + 12'h001);
            on_r  <= (smpl && monitor_power) ? on_r + 1 : 32'h0;
            off_r <= (smpl && !monitor_power) ? off_r + 1 : 32'h0;
        end
    end

    a_sd_trip_db: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(thermal_shutdown) |-> hi_r >= 12'h4E2)
        else $error("shutdown rose before trip input was steady");
    a_sd_rel_db: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(thermal_shutdown) |-> lo_r >= 12'h4E2)
        else $error("shutdown released before release input was steady");
    a_irq_masked: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == ttm_pkg::OFS_MASK && reg_wdata[6:0] == 7'h7F
        |=> !thermal_irq)
        else $error("irq high with every source masked");
    a_power_off: assert property (@(posedge sys_clk) disable iff (rst)
        reg_wr && reg_addr == ttm_pkg::OFS_CTRL && !reg_wdata[0]
        |-> ##4 !monitor_power)
        else $error("monitor still powered after enable cleared");
    a_aon_power: assert property (@(posedge sys_clk) disable iff (rst)
        (reg_wr && reg_addr == ttm_pkg::OFS_CTRL && reg_wdata[1:0] == 2'h3)
        ##1 run_state [*4] |-> monitor_power)
        else $error("monitor not powered in run with always-on");
    // pipeline of shadow to mode to power gives a few cycles of slack
    a_smpl_on: assert property (@(posedge sys_clk) disable iff (rst)
        on_r <= WIN_CYC + 4)
        else $error("sampling window too long");
    a_smpl_off: assert property (@(posedge sys_clk) disable iff (rst)
        off_r <= INT_CYC - WIN_CYC + 4)
        else $error("sampling gap too long");
    a_sense_sd: assert property (@(posedge sys_clk) disable iff (rst)
        reg_rd && reg_addr == ttm_pkg::OFS_SENSE
        |=> reg_rdata[7:6] == {1'b0, $past(thermal_shutdown)})
        else $error("sense shutdown bit differs from output");
    // a debounce flip launched in the last powered cycle lands two later
    a_off_frozen: assert property (@(posedge sys_clk) disable iff (rst)
        !monitor_power && !$past(monitor_power) && !$past(monitor_power, 2)
        |-> $stable(thermal_shutdown))
        else $error("shutdown changed while monitor unpowered");
endmodule

bind ttm_monitor ttm_monitor_chk #(
    .WIN_CYC(WIN_CYC),
    .INT_CYC(INT_CYC)
) i_ttm_monitor_chk (
    .sys_clk          (sys_clk),
    .rst              (rst),
    .run_state        (run_state),
    .cmp_sd_trip      (cmp_sd_trip),
    .cmp_sd_release   (cmp_sd_release),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .monitor_power    (monitor_power),
    .thermal_shutdown (thermal_shutdown),
    .thermal_irq      (thermal_irq)
);

//--- ttm_temp_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// centre sensor comparators driven from a temperature in C
// ------------------------------------------------------------
module ttm_temp_model #(
    parameter int SD_C = 165
) (
    input  wire logic [7:0]              temp_c,
    output logic [ttm_pkg::NTHR-1:0]     cmp_rise,
    output logic [ttm_pkg::NTHR-1:0]     cmp_release,
    output logic                         cmp_sd_trip,
    output logic                         cmp_sd_release
);
    // only the die-centre sensor is modelled, nothing else feeds in
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            cmp_rise[i]    = temp_c > 80 + 15 * i;
            cmp_release[i] = temp_c > 75 + 15 * i;
        end
        cmp_sd_trip    = temp_c > SD_C;
        cmp_sd_release = temp_c > SD_C - 15;
    end
endmodule

//--- ttm_monitor_tb.sv
`timescale 1ns/1ps
module ttm_monitor_tb;
    localparam int WIN  = 1400;
    localparam int PER  = 3000;
    localparam int SETL = 1300; // sync plus debounce plus slack
    localparam int SD_C = 165;
    logic                        sys_clk;
    logic                        rst;
    logic                        run_state;
    logic                        reg_wr;
    logic                        reg_rd;
    logic [7:0]                  reg_addr;
    logic [7:0]                  reg_wdata;
    logic [7:0]                  reg_rdata;
    logic [7:0]                  temp_c;
    logic [ttm_pkg::NTHR-1:0]    cmp_rise;
    logic [ttm_pkg::NTHR-1:0]    cmp_release;
    logic                        cmp_sd_trip;
    logic                        cmp_sd_release;
    logic                        monitor_power;
    logic                        thermal_shutdown;
    logic                        thermal_irq;
    logic [31:0]                 seed;
    logic [6:0]                  ex;
    logic [7:0]                  hy_t [7] = '{8'h64, 8'h5C, 8'h58, 8'hAA,
                                              8'hA0, 8'h98, 8'h8C};
    logic [6:0]                  hy_e [7] = '{7'h03, 7'h03, 7'h01, 7'h7F,
                                              7'h7F, 7'h7F, 7'h1F};
    logic [7:0]                  pw_c [4] = '{8'h01, 8'h00, 8'h03, 8'h03};
    logic                        pw_r [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    int                          pw_e [4] = '{WIN, 0, WIN, PER};
    // window comes first after entry, so sampling reads back powered
    logic [7:0]                  pw_s [4] = '{8'h03, 8'h00, 8'h03, 8'h01};
    int                          err_count;
    int                          num_checks;
    int                          cnt;

    ttm_monitor #(.WIN_CYC(WIN), .INT_CYC(PER)) i_ttm_monitor (
        .sys_clk(sys_clk), .rst(rst), .run_state(run_state),
        .cmp_rise(cmp_rise), .cmp_release(cmp_release),
        .cmp_sd_trip(cmp_sd_trip), .cmp_sd_release(cmp_sd_release),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .monitor_power(monitor_power),
        .thermal_shutdown(thermal_shutdown), .thermal_irq(thermal_irq));

    ttm_temp_model #(.SD_C(SD_C)) i_ttm_temp_model (
        .temp_c(temp_c), .cmp_rise(cmp_rise), .cmp_release(cmp_release),
        .cmp_sd_trip(cmp_sd_trip), .cmp_sd_release(cmp_sd_release));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected sense bits for a temperature reached from a cold start
    function automatic logic [6:0] exp_sense(input logic [7:0] t);
        for (int i = 0; i < 6; i++)
            exp_sense[i] = t > 80 + 15 * i;
        exp_sense[6] = t > SD_C;
    endfunction

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                          input string what);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(what, e, reg_rdata);
    endtask

    task automatic settle(input logic [7:0] t);
        temp_c <= t;
        repeat (SETL) @(posedge sys_clk);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and test sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // budget is more than twice the planned run length
    initial begin
        #(90000 * 8);
        err_count++;
        close_out();
    end

    initial begin
        rst = 1'b1; run_state = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
        reg_addr = 8'h00; reg_wdata = 8'h00; temp_c = 8'h14;
        seed = 32'h279506F1; err_count = 0; num_checks = 0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(ttm_pkg::OFS_MASK, 8'h7F, "mask");
        rd_chk(ttm_pkg::OFS_FLAG, 8'h00, "flag");
        rd_chk(ttm_pkg::OFS_CTRL, 8'h03, "ctrl");
        rd_chk(ttm_pkg::OFS_STATUS, 8'h01, "status");
        rd_chk(8'hA5, 8'h00, "unmapped");
        $display("test reset values done");
        wr(ttm_pkg::OFS_MASK, 8'h00);
        for (int n = 0; n < 6; n++) begin
            settle(8'h14);
            wr(ttm_pkg::OFS_FLAG, 8'h7F);
            seed = lfsr(seed);
            settle(8'h3C + {1'b0, seed[6:0]});
            ex = exp_sense(temp_c);
            rd_chk(ttm_pkg::OFS_SENSE, {1'b0, ex}, "sense");
            rd_chk(ttm_pkg::OFS_FLAG, {1'b0, ex}, "flag");
            chk("irq", {7'h00, |ex}, {7'h00, thermal_irq});
            chk("sd", {7'h00, ex[6]}, {7'h00, thermal_shutdown});
        end
        $display("test random temperatures done");
        settle(8'h14);
        for (int n = 0; n < 7; n++) begin
            settle(hy_t[n]);
            rd_chk(ttm_pkg::OFS_SENSE, {1'b0, hy_e[n]}, "hyst");
            chk("sd", {7'h00, hy_e[n][6]}, {7'h00, thermal_shutdown});
        end
        $display("test hysteresis done");
        wr(ttm_pkg::OFS_MASK, 8'h7F);
        chk("irq", 8'h00, {7'h00, thermal_irq});
        wr(ttm_pkg::OFS_MASK, 8'h00);
        chk("irq", 8'h01, {7'h00, thermal_irq});
        wr(ttm_pkg::OFS_FLAG, 8'h7F);
        chk("irq", 8'h00, {7'h00, thermal_irq});
        rd_chk(ttm_pkg::OFS_FLAG, 8'h00, "flag");
        $display("test mask and clear done");
        for (int n = 0; n < 4; n++) begin
            @(posedge sys_clk);
            run_state <= pw_r[n];
            wr(ttm_pkg::OFS_CTRL, pw_c[n]);
            repeat (10) @(posedge sys_clk);
            cnt = 0;
            repeat (PER) begin
                @(posedge sys_clk);
                #1;
                if (monitor_power === 1'b1)
                    cnt++;
            end
            chk("power", pw_e[n][7:0], cnt[7:0]);
            chk("powerh", pw_e[n][15:8], cnt[15:8]);
            rd_chk(ttm_pkg::OFS_STATUS, pw_s[n], "status");
            rd_chk(ttm_pkg::OFS_CTRL, pw_c[n], "ctrl");
        end
        $display("test power modes done");
        close_out();
    end
endmodule
